//--- serial_host_port_select.sv
// Shared-pad host port: I2C slave or 3/4-wire SPI slave onto one register bank
`timescale 1ns/1ps
`include "host_port_params.svh"

// Behaviour
// - One register bank behind both ports
// - SPI 3-wire or 4-wire by register bit
// - Both protocols share one set of pads
// - CS high: I2C on; CS low: SPI
// - Strap pin sets I2C address bit 1
// - 3-wire reads on data pad, 4-wire separate
// - Trim copied from NVM after power-up
// - Interrupt setup writable over either port
// - Address 0011110b strap high, 0011100b low
module serial_host_port_select #(
    parameter int TRIM_COUNT = `TRIM_COUNT
) (
    input wire logic mclk,
    input wire logic srst,
    input wire host_port_pkg::pad_in_t pad_in,
    output host_port_pkg::pad_out_t pad_out,
    output logic [3:0] nvm_addr,
    input wire logic [7:0] nvm_data,
    output logic trim_done,
    output logic spi_3wire,
    output host_port_pkg::int_setup_t int_setup
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [`PIN_COUNT-1:0] pin_raw;
    logic [`PIN_COUNT-1:0] s1_reg;
    logic [`PIN_COUNT-1:0] s2_reg;
    logic [`PIN_COUNT-1:0] s3_reg;
    logic [`PIN_COUNT-1:0] filt_reg;
    logic [`PIN_COUNT-1:0] prev_reg;

    assign pin_raw[`PIN_CS] = pad_in.cs_pin;
    assign pin_raw[`PIN_CLK] = pad_in.clk_pin;
    assign pin_raw[`PIN_DATA] = pad_in.data_pin;
    assign pin_raw[`PIN_STRAP] = pad_in.strap_pin;

    for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (srst) begin
                s1_reg[i] <= 1'b1;
                s2_reg[i] <= 1'b1;
                s3_reg[i] <= 1'b1;
            end else begin
                s1_reg[i] <= pin_raw[i];
                s2_reg[i] <= s1_reg[i];
                s3_reg[i] <= s2_reg[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            filt_reg <= `PIN_IDLE;
            prev_reg <= `PIN_IDLE;
        end else begin
            filt_reg <= (s2_reg ~^ s3_reg) & s3_reg | (s2_reg ^ s3_reg) & filt_reg;
            prev_reg <= filt_reg;
        end
    end

    logic cs_hi;
    logic clk_rise;
    logic clk_fall;
    logic data_rise;
    logic data_fall;
    assign cs_hi = filt_reg[`PIN_CS];
    assign clk_rise = filt_reg[`PIN_CLK] & ~prev_reg[`PIN_CLK];
    assign clk_fall = ~filt_reg[`PIN_CLK] & prev_reg[`PIN_CLK];
    assign data_rise = filt_reg[`PIN_DATA] & ~prev_reg[`PIN_DATA];
    assign data_fall = ~filt_reg[`PIN_DATA] & prev_reg[`PIN_DATA];

    ////////////////////////////////////////////////////////////////////////
    // Trim load
    logic [3:0] load_cnt_reg;
    logic [6:0] trim_addr;
    assign trim_addr = `TRIM_BASE + {3'h0, load_cnt_reg} - `PTR_STEP;

    always_ff @(posedge mclk) begin
        if (srst) begin
            load_cnt_reg <= 4'h0;
            trim_done <= 1'b0;
        end else if (!trim_done) begin
            load_cnt_reg <= load_cnt_reg + 4'h1;
            trim_done <= (load_cnt_reg == 4'(TRIM_COUNT));
        end
    end
    assign nvm_addr = load_cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bank and write steering
    logic i2c_we;
    logic spi_we;
    logic [6:0] i2c_ptr_reg;
    logic [6:0] spi_ptr_reg;
    logic [7:0] i2c_sh_reg;
    logic [7:0] spi_sh_reg;
    logic [6:0] ptr;
    logic bank_we;
    logic [6:0] bank_waddr;
    logic [7:0] bank_wdata;
    logic [7:0] rd_data;

    // CS level picks the active port
    assign ptr = cs_hi ? i2c_ptr_reg : spi_ptr_reg;

    // Both ports write the same bank
    always_comb begin
        bank_we = 1'b0;
        bank_waddr = ptr;
        bank_wdata = cs_hi ? i2c_sh_reg : {spi_sh_reg[6:0], filt_reg[`PIN_DATA]};
        if (!trim_done) begin
            bank_we = load_cnt_reg != 4'h0;
            bank_waddr = trim_addr;
            bank_wdata = nvm_data;
        end else begin
            bank_we = i2c_we | spi_we;
        end
    end

    reg_bank #(.AW(7), .DW(8)) u_bank (
        .mclk(mclk),
        .wr_en(bank_we),
        .wr_addr(bank_waddr),
        .wr_data(bank_wdata),
        .rd_addr(ptr),
        .rd_data(rd_data)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            spi_3wire <= 1'b0;
        end else if (bank_we && trim_done && bank_waddr == `CFG_ADDR) begin
            spi_3wire <= bank_wdata[`CFG_3WIRE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            int_setup <= '0;
        end else if (bank_we && trim_done) begin
            if (bank_waddr == `INT_CFG_ADDR) int_setup.int_cfg <= bank_wdata;
            if (bank_waddr == `INT_THS_LO_ADDR) int_setup.int_ths_lo <= bank_wdata;
            if (bank_waddr == `INT_THS_HI_ADDR) int_setup.int_ths_hi <= bank_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I2C slave
    host_port_pkg::i2c_state_t i2c_state_reg;
    logic [3:0] i2c_bit_reg;
    logic i2c_rw_reg;
    logic i2c_inc_reg;
    logic i2c_ack_reg;
    logic i2c_nack_reg;
    logic [7:0] i2c_tx_reg;
    logic i2c_on;
    logic i2c_start;
    logic i2c_stop;
    logic [6:0] own_addr;

    // I2C runs only while CS high
    assign i2c_on = cs_hi & trim_done;
    assign i2c_start = i2c_on & data_fall & filt_reg[`PIN_CLK];
    assign i2c_stop = i2c_on & data_rise & filt_reg[`PIN_CLK];
    assign own_addr = {`I2C_ADDR_HI, filt_reg[`PIN_STRAP], `I2C_ADDR_LO};
    assign i2c_we = i2c_on & clk_fall & (i2c_state_reg == host_port_pkg::I2C_WRITE)
                  & (i2c_bit_reg == `I2C_LAST_BIT);

    always_ff @(posedge mclk) begin
        if (srst || !i2c_on || i2c_stop) begin
            i2c_state_reg <= host_port_pkg::I2C_IDLE;
            i2c_bit_reg <= `I2C_BIT_ZERO;
            i2c_ack_reg <= 1'b0;
            i2c_nack_reg <= 1'b0;
        end else if (i2c_start) begin
            i2c_state_reg <= host_port_pkg::I2C_ADDR;
            i2c_bit_reg <= `I2C_BIT_ZERO;
            i2c_ack_reg <= 1'b0;
        end else if (clk_rise && i2c_state_reg != host_port_pkg::I2C_IDLE) begin
            if (i2c_bit_reg == `I2C_LAST_BIT) begin
                i2c_nack_reg <= filt_reg[`PIN_DATA];
                i2c_bit_reg <= `I2C_ACK_SLOT;
            end else begin
                i2c_sh_reg <= {i2c_sh_reg[6:0], filt_reg[`PIN_DATA]};
                i2c_bit_reg <= i2c_bit_reg + 4'h1;
            end
        end else if (clk_fall && i2c_state_reg != host_port_pkg::I2C_IDLE) begin
            if (i2c_bit_reg == `I2C_LAST_BIT) begin
                unique case (i2c_state_reg)
                    host_port_pkg::I2C_ADDR: begin
                        i2c_ack_reg <= i2c_sh_reg[7:1] == own_addr;
                        i2c_rw_reg <= i2c_sh_reg[0];
                        if (i2c_sh_reg[7:1] != own_addr) begin
                            i2c_state_reg <= host_port_pkg::I2C_IDLE;
                        end
                    end
                    host_port_pkg::I2C_SUB: begin
                        i2c_ack_reg <= 1'b1;
                        i2c_ptr_reg <= i2c_sh_reg[6:0];
                        i2c_inc_reg <= i2c_sh_reg[7];
                    end
                    host_port_pkg::I2C_WRITE: begin
                        i2c_ack_reg <= 1'b1;
                        if (i2c_inc_reg) i2c_ptr_reg <= i2c_ptr_reg + `PTR_STEP;
                    end
                    host_port_pkg::I2C_READ: i2c_ack_reg <= 1'b0;
                    default: i2c_ack_reg <= 1'b0;
                endcase
            end else if (i2c_bit_reg == `I2C_ACK_SLOT) begin
                i2c_ack_reg <= 1'b0;
                i2c_bit_reg <= `I2C_BIT_ZERO;
                unique case (i2c_state_reg)
                    host_port_pkg::I2C_ADDR: begin
                        if (i2c_rw_reg) begin
                            i2c_state_reg <= host_port_pkg::I2C_READ;
                            i2c_tx_reg <= rd_data;
                            if (i2c_inc_reg) i2c_ptr_reg <= i2c_ptr_reg + `PTR_STEP;
                        end else begin
                            i2c_state_reg <= host_port_pkg::I2C_SUB;
                        end
                    end
                    host_port_pkg::I2C_SUB: i2c_state_reg <= host_port_pkg::I2C_WRITE;
                    host_port_pkg::I2C_READ: begin
                        if (i2c_nack_reg) begin
                            i2c_state_reg <= host_port_pkg::I2C_IDLE;
                        end else begin
                            i2c_tx_reg <= rd_data;
                            if (i2c_inc_reg) i2c_ptr_reg <= i2c_ptr_reg + `PTR_STEP;
                        end
                    end
                    default: i2c_state_reg <= i2c_state_reg;
                endcase
            end else if (i2c_state_reg == host_port_pkg::I2C_READ) begin
                i2c_tx_reg <= {i2c_tx_reg[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SPI slave, clock parked high between frames
    logic spi_on;
    logic [2:0] spi_bit_reg;
    logic spi_cmd_done_reg;
    logic spi_rd_reg;
    logic spi_inc_reg;
    logic [7:0] spi_tx_reg;
    logic spi_drive;

    assign spi_on = ~cs_hi & trim_done;
    assign spi_we = spi_on & clk_rise & spi_cmd_done_reg & ~spi_rd_reg
                  & (spi_bit_reg == `SPI_LAST_BIT);
    assign spi_drive = spi_on & spi_cmd_done_reg & spi_rd_reg;

    always_ff @(posedge mclk) begin
        if (srst || !spi_on) begin
            spi_bit_reg <= `SPI_BIT_ZERO;
            spi_cmd_done_reg <= 1'b0;
            spi_rd_reg <= 1'b0;
            spi_inc_reg <= 1'b0;
            spi_tx_reg <= `BYTE_ZERO;
        end else if (clk_rise) begin
            spi_sh_reg <= {spi_sh_reg[6:0], filt_reg[`PIN_DATA]};
            spi_bit_reg <= spi_bit_reg + 3'h1;
            if (spi_bit_reg == `SPI_LAST_BIT) begin
                if (!spi_cmd_done_reg) begin
                    spi_cmd_done_reg <= 1'b1;
                    spi_rd_reg <= spi_sh_reg[6];
                    spi_inc_reg <= spi_sh_reg[5];
                    spi_ptr_reg <= {1'b0, spi_sh_reg[4:0], filt_reg[`PIN_DATA]};
                end else if (spi_inc_reg) begin
                    spi_ptr_reg <= spi_ptr_reg + `PTR_STEP;
                end
            end
        end else if (clk_fall && spi_drive) begin
            if (spi_bit_reg == `SPI_BIT_ZERO) begin
                spi_tx_reg <= rd_data;
            end else begin
                spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad drivers, enables active low
    always_ff @(posedge mclk) begin
        if (srst) begin
            pad_out <= {1'b0, 1'b1, 1'b0, 1'b1};
        end else begin
            pad_out.data_o <= 1'b0;
            pad_out.data_oe_n <= 1'b1;
            pad_out.out_o <= spi_tx_reg[7];
            pad_out.out_oe_n <= 1'b1;
            if (i2c_on) begin
                pad_out.data_oe_n <= ~(i2c_ack_reg | (i2c_state_reg == host_port_pkg::I2C_READ
                                     & i2c_bit_reg < `I2C_LAST_BIT & ~i2c_tx_reg[7]));
            end else if (spi_drive && spi_3wire) begin
                pad_out.data_o <= spi_tx_reg[7];
                pad_out.data_oe_n <= 1'b0;
            end else if (spi_drive) begin
                pad_out.out_oe_n <= 1'b0;
            end
        end
    end

endmodule : serial_host_port_select

//--- host_port_params.svh
// Offsets, field positions, reset values and counts of the serial host port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define PIN_CS 0
`define PIN_CLK 1
`define PIN_DATA 2
`define PIN_STRAP 3
`define PIN_COUNT 4
`define PIN_IDLE 4'hf

`define I2C_ADDR_HI 5'h07
`define I2C_ADDR_LO 1'h0
`define I2C_LAST_BIT 4'h8
`define I2C_ACK_SLOT 4'h9
`define I2C_BIT_ZERO 4'h0

`define SPI_LAST_BIT 3'h7
`define SPI_BIT_ZERO 3'h0

`define CFG_ADDR 7'h22
`define CFG_3WIRE_BIT 2
`define INT_CFG_ADDR 7'h30
`define INT_THS_LO_ADDR 7'h32
`define INT_THS_HI_ADDR 7'h33
`define TRIM_BASE 7'h40
`define TRIM_COUNT 8
`define BYTE_ZERO 8'h00
`define PTR_STEP 7'h01

`endif

//--- host_port_pkg.sv
// Types of the serial host port
package host_port_pkg;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_SUB,
        I2C_WRITE,
        I2C_READ
    } i2c_state_t;

    typedef struct packed {
        logic clk_pin;
        logic data_pin;
        logic strap_pin;
        logic cs_pin;
    } pad_in_t;

    typedef struct packed {
        logic data_o;
        logic data_oe_n;
        logic out_o;
        logic out_oe_n;
    } pad_out_t;

    typedef struct packed {
        logic [7:0] int_cfg;
        logic [7:0] int_ths_lo;
        logic [7:0] int_ths_hi;
    } int_setup_t;

endpackage : host_port_pkg

//--- reg_bank.sv
// Register bank shared by both serial ports
`timescale 1ns/1ps

module reg_bank #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        rd_data <= mem[rd_addr];
    end

endmodule : reg_bank

//--- host_port_properties.sv
// Checker for the shared-pad host port, bound to its top module
`timescale 1ns/1ps
module host_port_properties #(
    parameter int TRIM_COUNT = 8
) (
    input wire logic mclk,
    input wire logic srst,
    input wire host_port_pkg::pad_in_t pad_in,
    input wire host_port_pkg::pad_out_t pad_out,
    input wire logic [3:0] nvm_addr,
    input wire logic trim_done,
    input wire logic spi_3wire,
    input wire host_port_pkg::int_setup_t int_setup
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    reset_state_a: assert property (disable iff (1'b0) srst |=> pad_out.data_oe_n &&
        pad_out.out_oe_n && !trim_done && nvm_addr == 4'h0 && !spi_3wire && int_setup == 24'h0)
        else $error("state after reset wrong");
    trim_time_a: assert property ($fell(srst) |-> ##[1:40] trim_done)
        else $error("trim copy too slow");
    trim_hold_a: assert property (trim_done |=> trim_done)
        else $error("trim done dropped");
    nvm_step_a: assert property (!trim_done && !$past(srst) &&
        nvm_addr < 4'(TRIM_COUNT) |=> nvm_addr == $past(nvm_addr) + 4'h1)
        else $error("trim address did not step");
    ports_quiet_a: assert property (!trim_done |-> pad_out.data_oe_n && pad_out.out_oe_n)
        else $error("pad driven before trim");
    i2c_out_idle_a: assert property (pad_in.cs_pin [*8] |-> pad_out.out_oe_n)
        else $error("output pad driven in I2C mode");
    i2c_drain_a: assert property (pad_in.cs_pin [*8] ##0 !pad_out.data_oe_n
        |-> !pad_out.data_o)
        else $error("data pad driven high in I2C");
    three_wire_a: assert property (spi_3wire |-> pad_out.out_oe_n)
        else $error("output pad used in 3-wire");
    four_wire_a: assert property ((!spi_3wire && !pad_in.cs_pin) [*8] |->
        pad_out.data_oe_n)
        else $error("data pad driven in 4-wire");
    cover property ($rose(trim_done));
    cover property (!pad_out.out_oe_n);
    cover property (!pad_out.data_oe_n && !pad_in.cs_pin);
    cover property ($rose(spi_3wire));
endmodule : host_port_properties

bind serial_host_port_select host_port_properties #(.TRIM_COUNT(TRIM_COUNT))
    i_host_port_properties (
    .mclk(mclk), .srst(srst), .pad_in(pad_in), .pad_out(pad_out), .nvm_addr(nvm_addr),
    .trim_done(trim_done), .spi_3wire(spi_3wire), .int_setup(int_setup));

//--- host_master.sv
// Host controller model driving the shared serial pads
`timescale 1ns/1ps
module host_master (
    input wire logic mclk,
    input wire logic strap_lvl,
    input wire host_port_pkg::pad_out_t pad_out,
    output host_port_pkg::pad_in_t pad_in
);
    localparam int H = 8;
    logic scl = 1'h1;
    logic sda = 1'h1;
    logic cs = 1'h1;
    logic sda_w;
    logic strap_w;
    assign sda_w = sda & (pad_out.data_oe_n | pad_out.data_o);
    assign strap_w = pad_out.out_oe_n ? strap_lvl : pad_out.out_o;
    assign pad_in = {scl, sda_w, strap_w, cs};
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask : w
    ////////////////////////////////////////////////////////////////////////////////
    // CS frame, clock parked high
    task automatic spi(input logic tw, input logic [15:0] cmd, output logic [7:0] rd);
        cs = 1'h0;
        w(H);
        for (int i = 15; i >= 0; i--) begin
            scl = 1'h0;
            sda = (cmd[15] && i < 8) ? 1'h1 : cmd[i];
            w(H);
            if (i < 8) rd[i] = tw ? sda_w : strap_w;
            scl = 1'h1;
            w(H);
        end
        sda = 1'h1;
        cs = 1'h1;
        w(4 * H);
    endtask : spi
    task automatic bit_io(input logic b, output logic s);
        sda = b;
        w(H);
        scl = 1'h1;
        w(H / 2);
        s = sda_w;
        w(H / 2);
        scl = 1'h0;
        w(2);
    endtask : bit_io
    task automatic xb(input logic [7:0] b, output logic [7:0] r, output logic s);
        for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
        bit_io(1'h1, s);
    endtask : xb
    task automatic i2c(input logic [7:0] sad, input logic [7:0] sub, input logic [7:0] dat,
                       input logic rdf, output logic [7:0] rd, output logic ack);
        logic [7:0] r;
        logic s0, s1, s2, s3;
        cs = 1'h1;
        sda = 1'h0;
        w(H);
        scl = 1'h0;
        w(H);
        xb(sad, r, s0);
        xb(sub, r, s1);
        if (rdf) begin
            w(H);
            scl = 1'h1;
            w(H);
            sda = 1'h0;
            w(H);
            scl = 1'h0;
            w(H);
            xb(sad | 8'h01, r, s2);
            xb(8'hff, rd, s3);
        end else begin
            xb(dat, r, s2);
        end
        ack = !(s0 | s1 | s2);
        sda = 1'h0;
        w(H);
        scl = 1'h1;
        w(H);
        sda = 1'h1;
        w(4 * H);
    endtask : i2c
endmodule : host_master

//--- serial_host_port_select_test.sv
// Self-checking bench of the shared-pad host port
`timescale 1ns/1ps
module serial_host_port_select_test;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic strap_lvl = 1'h1;
    logic [7:0] nvm_data = 8'h00;
    logic [3:0] nvm_addr;
    logic trim_done;
    logic spi_3wire;
    logic [7:0] rd;
    logic ack;
    host_port_pkg::pad_in_t pad_in;
    host_port_pkg::pad_out_t pad_out;
    host_port_pkg::int_setup_t int_setup;
    int miscompares = 0;
    int num_checks = 0;
    initial forever #4 mclk = ~mclk;
    logic [3:0] nvm_prev = 4'h0;
    // Trim memory answers one cycle after the address
    always @(negedge mclk) begin
        nvm_prev <= nvm_addr;
        nvm_data <= 8'ha0 + {4'h0, nvm_prev};
    end
    serial_host_port_select #(.TRIM_COUNT(8)) i_serial_host_port_select (.mclk(mclk),
        .srst(srst), .pad_in(pad_in), .pad_out(pad_out), .nvm_addr(nvm_addr),
        .nvm_data(nvm_data), .trim_done(trim_done), .spi_3wire(spi_3wire), .int_setup(int_setup));
    host_master i_host_master (.mclk(mclk), .strap_lvl(strap_lvl), .pad_out(pad_out),
        .pad_in(pad_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic t_trim();
        int n;
        n = 0;
        while (trim_done !== 1'h1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        check("trim_done", {7'h0, trim_done}, 8'h01);
        if (n == 100) close_out();
        i_host_master.i2c(8'h3c, 8'h40, 8'h00, 1'h1, rd, ack);
        check("trim first", rd, 8'ha0);
        i_host_master.i2c(8'h3c, 8'h47, 8'h00, 1'h1, rd, ack);
        check("trim last", rd, 8'ha7);
        $display("t_trim done");
    endtask : t_trim
    task automatic t_i2c();
        i_host_master.i2c(8'h3c, 8'h30, 8'h5a, 1'h0, rd, ack);
        check("ack strap high", {7'h0, ack}, 8'h01);
        check("int_cfg", int_setup.int_cfg, 8'h5a);
        strap_lvl = 1'h0;
        repeat (16) @(negedge mclk);
        i_host_master.i2c(8'h38, 8'h32, 8'hc3, 1'h0, rd, ack);
        check("ack strap low", {7'h0, ack}, 8'h01);
        check("int_ths_lo", int_setup.int_ths_lo, 8'hc3);
        i_host_master.i2c(8'h3c, 8'h33, 8'hff, 1'h0, rd, ack);
        check("ack wrong addr", {7'h0, ack}, 8'h00);
        check("int_ths_hi kept", int_setup.int_ths_hi, 8'h00);
        $display("t_i2c done");
    endtask : t_i2c
    task automatic t_spi();
        i_host_master.spi(1'h0, {2'h0, 6'h33, 8'h81}, rd);
        check("int_ths_hi", int_setup.int_ths_hi, 8'h81);
        i_host_master.spi(1'h0, {2'h2, 6'h30, 8'h00}, rd);
        check("spi read 4w", rd, 8'h5a);
        i_host_master.i2c(8'h38, 8'h33, 8'h00, 1'h1, rd, ack);
        check("i2c read back", rd, 8'h81);
        i_host_master.spi(1'h0, {2'h0, 6'h22, 8'h04}, rd);
        check("spi_3wire", {7'h0, spi_3wire}, 8'h01);
        i_host_master.spi(1'h1, {2'h2, 6'h32, 8'h00}, rd);
        check("spi read 3w", rd, 8'hc3);
        $display("t_spi done");
    endtask : t_spi
    initial begin
        repeat (16) @(negedge mclk);
        srst = 1'h0;
        t_trim();
        t_i2c();
        t_spi();
        close_out();
    end
endmodule : serial_host_port_select_test
